// ==== tb_top.sv ====
// Self-checking bench for the wake gating block: APB master and pin drive.
// Assumes the shared wake line has a pull-up that the bench can also pull low.
`timescale 1ns/1ps
`include "wk_map.svh"

module tb_top;
    // =====================================================================
    // Signals
    localparam logic [7:0] A_ST1 = {`WK_IDX_STATUS_GPIO_GROUP1, 2'h0};
    localparam logic [7:0] A_ST2 = {`WK_IDX_STATUS_GPIO_GROUP2, 2'h0};
    localparam logic [7:0] A_EN1 = {`WK_IDX_ENABLE_GPIO_GROUP1, 2'h0};
    localparam logic [7:0] A_EN2 = {`WK_IDX_ENABLE_GPIO_GROUP2, 2'h0};
    localparam logic [7:0] A_CTL = {`WK_IDX_CONTROL, 2'h0};
    localparam logic [7:0] A_IST = {`WK_IDX_IRQ_STATUS, 2'h0};
    localparam logic [7:0] A_IMK = {`WK_IDX_IRQ_MASK, 2'h0};
    localparam logic [7:0] A_PIN = {`WK_IDX_PIN_LEVEL, 2'h0};
    logic        mclk           = 1'b0;
    logic        srst           = 1'b1;
    logic        otherReset     = 1'b0;
    logic [7:0]  paddr          = 8'h00;
    logic        psel           = 1'b0;
    logic        penable        = 1'b0;
    logic        pwrite         = 1'b0;
    logic [31:0] pwdata         = 32'h0;
    logic [3:0]  pstrb          = 4'h0;
    logic [3:0]  strb           = 4'hf;
    logic [7:0]  gpioWakeGroup1 = 8'h00;
    logic [7:0]  gpioWakeGroup2 = 8'h00;
    logic        foreignLow     = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        wakeOutNOut;
    logic        wakeOutNOeN;
    logic        irq;
    logic        irq0;
    logic [31:0] rd;
    logic        err;
    wire logic   wakeOutNIn;
    int          num_errors     = 0;
    int          n_compared     = 0;

    // Wire level from our drive, the pull-up and a foreign driver
    assign wakeOutNIn = foreignLow ? 1'b0 : (wakeOutNOeN ? 1'b1 : wakeOutNOut);
    always #2 mclk = ~mclk;

    wk_wake_gate dut (.mclk(mclk), .srst(srst), .otherReset(otherReset), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .gpioWakeGroup1(gpioWakeGroup1), .gpioWakeGroup2(gpioWakeGroup2),
        .wakeOutNIn(wakeOutNIn), .wakeOutNOut(wakeOutNOut), .wakeOutNOeN(wakeOutNOeN), .irq(irq));

    // =====================================================================
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; waits on pready, never on a fixed count
    task automatic apb(input logic [7:0] a, input logic wr, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel    <= 1'b1;
        paddr   <= a;
        pwrite  <= wr;
        pwdata  <= d;
        pstrb   <= strb;
        @(posedge mclk);
        penable <= 1'b1;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        check(n < 20, 1'b1);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic pin(input int g, input int i, input logic v);
        @(posedge mclk);
        if (g == 0)
            gpioWakeGroup1[i] <= v;
        else
            gpioWakeGroup2[i] <= v;
    endtask

    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // =====================================================================
    // Scenarios
    task automatic t_reset;
        logic [7:0] regs [5];
        regs = '{A_EN1, A_EN2, A_ST1, A_ST2, A_CTL};
        foreach (regs[k])
        begin
            apb(regs[k], 1'b0, 32'h0);
            check(rd, 32'h0);
        end
        check(wakeOutNOeN, 1'b1);
        check(wakeOutNOut, 1'b0);
    endtask

    // Each source alone: wrong enables hold off, its own enable drives
    task automatic t_map;
        logic [7:0] st;
        logic [7:0] en;
        apb(A_CTL, 1'b1, 32'h1);
        for (int g = 0; g < 2; g++)
            for (int i = 0; i < 8; i++)
            begin
                st = g ? A_ST2 : A_ST1;
                en = g ? A_EN2 : A_EN1;
                apb(en, 1'b1, ~(32'h1 << i) & 32'hff);
                pin(g, i, 1'b1);
                cyc(6);
                check(wakeOutNOeN, 1'b1);
                apb(st, 1'b0, 32'h0);
                check(rd, 32'h1 << i);
                apb(en, 1'b1, 32'h1 << i);
                cyc(2);
                check(wakeOutNOeN, 1'b0);
                apb(st, 1'b1, 32'h1 << i);
                cyc(3);
                check(wakeOutNOeN, 1'b1);
                pin(g, i, 1'b0);
                cyc(3);
            end
    endtask

    // Global enable gates, then both registers OR onto the line
    task automatic t_global_or;
        apb(A_CTL, 1'b1, 32'h0);
        apb(A_EN1, 1'b1, 32'h1);
        apb(A_EN2, 1'b1, 32'h1);
        pin(0, 0, 1'b1);
        pin(1, 0, 1'b1);
        cyc(6);
        check(wakeOutNOeN, 1'b1);
        apb(A_CTL, 1'b1, 32'h1);
        cyc(2);
        check(wakeOutNOeN, 1'b0);
        apb(A_PIN, 1'b0, 32'h0);
        check(rd, 32'h1);
        apb(A_ST2, 1'b1, 32'h0);
        apb(A_ST2, 1'b0, 32'h0);
        check(rd, 32'h1);
        apb(A_ST1, 1'b1, 32'h1);
        cyc(3);
        check(wakeOutNOeN, 1'b0);
        apb(A_ST2, 1'b1, 32'h1);
        cyc(3);
        check(wakeOutNOeN, 1'b1);
    endtask

    // Other resets keep enables; unmapped index is refused
    task automatic t_keep_bus;
        @(posedge mclk);
        otherReset <= 1'b1;
        cyc(2);
        otherReset <= 1'b0;
        strb = 4'he;
        apb(A_EN1, 1'b1, 32'h0);
        strb = 4'hf;
        apb(A_EN1, 1'b0, 32'h0);
        check(rd, 32'h1);
        apb(A_CTL, 1'b0, 32'h0);
        check(rd, 32'h1);
        apb(8'h04, 1'b0, 32'h0);
        check(err, 1'b1);
        check(rd, 32'h0);
    endtask

    // Masking flips the line, a read clears, a foreign low is flagged
    task automatic t_irq;
        apb(A_IMK, 1'b1, 32'h0);
        pin(0, 2, 1'b1);
        cyc(6);
        irq0 = irq;
        apb(A_IMK, 1'b1, 32'h7);
        cyc(2);
        check(irq0, 1'b0);
        check(irq, 1'b1);
        apb(A_IST, 1'b0, 32'h0);
        check(rd[0], 1'b1);
        apb(A_IST, 1'b0, 32'h0);
        check(rd[0], 1'b0);
        foreignLow <= 1'b1;
        cyc(5);
        apb(A_PIN, 1'b0, 32'h0);
        check(rd, 32'h0);
        apb(A_IST, 1'b0, 32'h0);
        check(rd[2], 1'b1);
        foreignLow <= 1'b0;
        gpioWakeGroup1 <= 8'h00;
        gpioWakeGroup2 <= 8'h00;
    endtask

    // =====================================================================
    // Main sequence, second reset after the scenarios, watchdog
    initial
    begin
        cyc(3);
        srst <= 1'b0;
        cyc(3);
        t_reset();
        t_map();
        t_global_or();
        t_keep_bus();
        t_irq();
        @(posedge mclk);
        srst <= 1'b1;
        cyc(3);
        srst <= 1'b0;
        t_reset();
        test_done();
    end

    initial
    begin
        #100000;
        num_errors++;
        test_done();
    end
endmodule

// ==== wk_map.svh ====
// Register map, field positions, reset values and widths of the wake gating block.
// Assumes inclusion by bare name from the block's package and modules.
`ifndef WK_MAP_SVH
`define WK_MAP_SVH

// =====================================================================
// Register indices (byte address is four times the index)
`define WK_IDX_STATUS_GPIO_GROUP1   6'h05
`define WK_IDX_STATUS_GPIO_GROUP2   6'h06
`define WK_IDX_ENABLE_GPIO_GROUP1   6'h0b
`define WK_IDX_ENABLE_GPIO_GROUP2   6'h0c
`define WK_IDX_CONTROL              6'h20
`define WK_IDX_IRQ_STATUS           6'h21
`define WK_IDX_IRQ_MASK             6'h22
`define WK_IDX_PIN_LEVEL            6'h23

// =====================================================================
// Field positions
`define WK_BIT_GROUPED_MGMT_IRQ     3
`define WK_BIT_GLOBAL_WAKE_ENABLE   0
`define WK_IRQ_NEW_STATUS           0
`define WK_IRQ_WAKE_ASSERTED        1
`define WK_IRQ_FOREIGN_WAKE         2
`define WK_PIN_DRIVING              0
`define WK_PIN_BUS_LEVEL            1

// =====================================================================
// Reset values
`define WK_RESET_ENABLE             8'h00
`define WK_RESET_STATUS             8'h00
`define WK_RESET_CONTROL            8'h00
`define WK_RESET_IRQ                3'h0
`define WK_RESET_RDATA              32'h0000_0000

// =====================================================================
// Widths
`define WK_REG_WIDTH                8
`define WK_IRQ_WIDTH                3

`endif

// ==== wk_pkg.sv ====
// Types shared by the wake gating block.
// Assumes wk_map.svh is on the include path.
`include "wk_map.svh"

package wk_pkg;

    // =====================================================================
    // Data types
    typedef logic [`WK_REG_WIDTH-1:0] wk_byte_type;
    typedef logic [`WK_IRQ_WIDTH-1:0] wk_irq_type;

    // Register selected by the current bus address
    typedef enum logic [2:0] {
        WK_SEL_NONE,
        WK_SEL_STATUS1,
        WK_SEL_STATUS2,
        WK_SEL_ENABLE1,
        WK_SEL_ENABLE2,
        WK_SEL_CONTROL,
        WK_SEL_IRQ_STATUS,
        WK_SEL_IRQ_MASK
    } wk_sel_type;

endpackage

// ==== wk_sticky.sv ====
// Sticky flag register: hardware sets, software clears by mask.
// Assumes set and clear come from logic on mclk.
`timescale 1ns/1ps

module wk_sticky #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             srst,
    // Set and clear
    input  wire logic [WIDTH-1:0] setBits,
    input  wire logic [WIDTH-1:0] clearBits,
    output logic      [WIDTH-1:0] flags
);

    logic [WIDTH-1:0] next_flags;

    // Set is applied after clear so a same-cycle event is never lost
    assign next_flags = (flags & ~clearBits) | setBits;

    // =====================================================================
    // Flag storage
    always_ff @(posedge mclk)
    begin
        if (srst)
            flags <= '0;
        else
            flags <= next_flags;
    end

endmodule

// ==== wk_sync_edge.sv ====
// Two-flop synchroniser with rising-edge detect for a group of pin inputs.
// Assumes pins are asynchronous to mclk; edges shorter than a cycle may be missed.
`timescale 1ns/1ps

module wk_sync_edge #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             srst,
    // Pins and results
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] rise
);

    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] prev;

    // =====================================================================
    // Synchroniser; the first stage feeds only the second
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            meta  <= '0;
            level <= '0;
            prev  <= '0;
        end
        else
        begin
            meta  <= pinIn;
            level <= meta;
            prev  <= level;
        end
    end

    // Edge detect on the settled stage only
    assign rise = level & ~prev;

endmodule

// ==== wk_wake_gate.sv ====
// Wake event gating: status capture, per-source enables, global enable,
// open-drain wake output, APB register slave and a maskable interrupt.
// Assumes srst is the standby-supply power-on reset and that other resets
// reach only the otherReset input; pins arrive asynchronously to mclk.
//
// Operation
// (RULE1) Wake output asserts low when source enable, status and global enable are one.
// (RULE2) Disabled source still records status but never drives the wake output.
// (RULE3) Enable register 0x0B bits 0..7 gate pins ten through seventeen.
// (RULE4) Bit 3 of enable register 0x0C gates the grouped management interrupt.
// (RULE5) Other 0x0C bits gate pins 20,21,22,24,25,26,27 on bits 0,1,2,4..7.
// (RULE6) Enable registers reset to zero only on standby power-on reset.
// (RULE7) Status bit sets on a source wake event regardless of any enable.
// (RULE8) Writing one clears a status bit; writing zero leaves it alone.
// (RULE9) Wake output is the OR of all gated sources across both registers.
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "wk_map.svh"

module wk_wake_gate (
    // Clock and standby power-on reset
    input  wire logic        mclk,
    input  wire logic        srst,
    // Main-supply, soft and hard reset, merged; leaves the wake state alone
    input  wire logic        otherReset,
    // APB slave
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Wake sources (pins ten..seventeen; pins twenty..twenty_seven with
    // the grouped management interrupt on bit 3)
    input  wire logic [7:0]  gpioWakeGroup1,
    input  wire logic [7:0]  gpioWakeGroup2,
    // Open-drain wake line
    input  wire logic        wakeOutNIn,
    output logic             wakeOutNOut,
    output logic             wakeOutNOeN,
    // Interrupt
    output logic             irq
);

    // =====================================================================
    // Declarations
    wk_pkg::wk_byte_type wakeEnableGpioGroup1;
    wk_pkg::wk_byte_type wakeEnableGpioGroup2;
    wk_pkg::wk_byte_type controlReg;
    wk_pkg::wk_irq_type  irqMask;
    wk_pkg::wk_byte_type wakeStatus1;
    wk_pkg::wk_byte_type wakeStatus2;
    wk_pkg::wk_irq_type  irqStatus;
    wk_pkg::wk_sel_type  regSel;

    logic [7:0]  pinLevel1;
    logic [7:0]  pinLevel2;
    logic [7:0]  pinRise1;
    logic [7:0]  pinRise2;
    logic [0:0]  busLevel;
    logic [0:0]  busRiseUnused;

    logic [5:0]  regIndex;
    logic        setupPhase;
    logic        accessDone;
    logic        writeFire;
    logic        readFire;
    logic        laneZero;
    logic        unmapped;
    logic        pinLevelSel;
    logic [31:0] readMux;
    logic        next_pready;

    logic [7:0]  gated1;
    logic [7:0]  gated2;
    logic        globalWakeEnable;
    logic        anyGated;
    logic        wakeActive;
    logic        wakeActiveLast;

    logic [7:0]  status1Clear;
    logic [7:0]  status2Clear;
    logic [2:0]  irqSet;
    logic [2:0]  irqClear;
    logic        next_irq;

    // Our own release, delayed to line up with the synchronised line level
    logic        releasedD1;
    logic        releasedD2;
    logic        releasedSettled;

    // =====================================================================
    // Pin synchronisers
    // Wake sources are edge events; a level held high sets the flag once
    wk_sync_edge #(
        .WIDTH (8)
    ) u_sync_group1 (
        .mclk  (mclk),
        .srst  (srst),
        .pinIn (gpioWakeGroup1),
        .level (pinLevel1),
        .rise  (pinRise1)
    );

    wk_sync_edge #(
        .WIDTH (8)
    ) u_sync_group2 (
        .mclk  (mclk),
        .srst  (srst),
        .pinIn (gpioWakeGroup2),
        .level (pinLevel2),
        .rise  (pinRise2)
    );

    // The wake line is shared; sample it to see other devices pulling it
    wk_sync_edge #(
        .WIDTH (1)
    ) u_sync_bus (
        .mclk  (mclk),
        .srst  (srst),
        .pinIn (wakeOutNIn),
        .level (busLevel),
        .rise  (busRiseUnused)
    );

    // =====================================================================
    // APB decode
    // Printed offsets are indices; word addresses are index times four
    assign regIndex    = paddr[7:2];
    assign setupPhase  = psel & ~penable;
    assign accessDone  = psel & penable & pready;
    assign writeFire   = accessDone & pwrite;
    assign readFire    = accessDone & ~pwrite;
    assign laneZero    = writeFire & pstrb[0];
    assign next_pready = psel & penable & ~pready;  // One wait state

    // Address to register select
    assign regSel = (regIndex == `WK_IDX_STATUS_GPIO_GROUP1) ? wk_pkg::WK_SEL_STATUS1 :
                    (regIndex == `WK_IDX_STATUS_GPIO_GROUP2) ? wk_pkg::WK_SEL_STATUS2 :
                    (regIndex == `WK_IDX_ENABLE_GPIO_GROUP1) ? wk_pkg::WK_SEL_ENABLE1 :
                    (regIndex == `WK_IDX_ENABLE_GPIO_GROUP2) ? wk_pkg::WK_SEL_ENABLE2 :
                    (regIndex == `WK_IDX_CONTROL)            ? wk_pkg::WK_SEL_CONTROL :
                    (regIndex == `WK_IDX_IRQ_STATUS)         ? wk_pkg::WK_SEL_IRQ_STATUS :
                    (regIndex == `WK_IDX_IRQ_MASK)           ? wk_pkg::WK_SEL_IRQ_MASK :
                                                               wk_pkg::WK_SEL_NONE;

    // The pin level register is read-only and sits outside the select enum
    assign pinLevelSel = (regIndex == `WK_IDX_PIN_LEVEL);
    assign unmapped    = (regSel == wk_pkg::WK_SEL_NONE) & ~pinLevelSel;

    // =====================================================================
    // Read data selection; narrow registers sit in the low bits
    always_comb
    begin
        readMux = `WK_RESET_RDATA;
        case (regSel)
            wk_pkg::WK_SEL_STATUS1:    readMux[7:0] = wakeStatus1;
            wk_pkg::WK_SEL_STATUS2:    readMux[7:0] = wakeStatus2;
            wk_pkg::WK_SEL_ENABLE1:    readMux[7:0] = wakeEnableGpioGroup1;
            wk_pkg::WK_SEL_ENABLE2:    readMux[7:0] = wakeEnableGpioGroup2;
            wk_pkg::WK_SEL_CONTROL:    readMux[7:0] = controlReg;
            wk_pkg::WK_SEL_IRQ_STATUS: readMux[2:0] = irqStatus;
            wk_pkg::WK_SEL_IRQ_MASK:   readMux[2:0] = irqMask;
            default:
            begin
                if (pinLevelSel)
                begin
                    readMux[`WK_PIN_DRIVING]   = wakeActive;
                    readMux[`WK_PIN_BUS_LEVEL] = busLevel[0];
                end
            end
        endcase
    end

    // =====================================================================
    // Bus answer; data is caught in setup so it stands through the access
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            pready  <= 1'b0;
            prdata  <= `WK_RESET_RDATA;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= next_pready;
            if (setupPhase)
            begin
                prdata  <= pwrite ? `WK_RESET_RDATA : readMux;
                pslverr <= unmapped;
            end
        end
    end

    // =====================================================================
    // Enable registers; only the standby reset clears them
    // otherReset is deliberately not looked at here
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            wakeEnableGpioGroup1 <= `WK_RESET_ENABLE;      // [RULE6]
            wakeEnableGpioGroup2 <= `WK_RESET_ENABLE;      // [RULE6]
            controlReg           <= `WK_RESET_CONTROL;
        end
        else if (laneZero)
        begin
            if (regSel == wk_pkg::WK_SEL_ENABLE1)
                wakeEnableGpioGroup1 <= pwdata[7:0];       // [RULE3]
            if (regSel == wk_pkg::WK_SEL_ENABLE2)
                wakeEnableGpioGroup2 <= pwdata[7:0];       // [RULE4] [RULE5]
            if (regSel == wk_pkg::WK_SEL_CONTROL)
                controlReg <= pwdata[7:0];
        end
    end

    assign globalWakeEnable = controlReg[`WK_BIT_GLOBAL_WAKE_ENABLE];

    // =====================================================================
    // Wake status; set by source edges, cleared by writing ones
    // Clears come from lane zero only, so a write without lane zero cannot clear them
    assign status1Clear = (laneZero && regSel == wk_pkg::WK_SEL_STATUS1) ? pwdata[7:0] : 8'h00; // [RULE8]
    assign status2Clear = (laneZero && regSel == wk_pkg::WK_SEL_STATUS2) ? pwdata[7:0] : 8'h00; // [RULE8]

    // Status capture ignores both the per-source and global enables
    wk_sticky #(
        .WIDTH (8)
    ) u_status_group1 (
        .mclk      (mclk),
        .srst      (srst),
        .setBits   (pinRise1),                             // [RULE7]
        .clearBits (status1Clear),
        .flags     (wakeStatus1)
    );

    wk_sticky #(
        .WIDTH (8)
    ) u_status_group2 (
        .mclk      (mclk),
        .srst      (srst),
        .setBits   (pinRise2),                             // [RULE7]
        .clearBits (status2Clear),
        .flags     (wakeStatus2)
    );

    // =====================================================================
    // Gating: each bit needs its enable, its status and the global enable
    // Bit order matches the status layout, so gating is a plain AND
    assign gated1   = wakeEnableGpioGroup1 & wakeStatus1;   // [RULE1] [RULE2] [RULE3]
    assign gated2   = wakeEnableGpioGroup2 & wakeStatus2;   // [RULE1] [RULE2] [RULE4] [RULE5]
    assign anyGated = (|gated1) | (|gated2);                // [RULE9]
    assign wakeActive = anyGated & globalWakeEnable;         // [RULE1]

    // =====================================================================
    // Open-drain wake line; drive value is always low, enable does the work
    // Registered so the pad sees no decode glitches
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            wakeOutNOut    <= 1'b0;
            wakeOutNOeN    <= 1'b1;
            wakeActiveLast <= 1'b0;
        end
        else
        begin
            wakeOutNOut    <= 1'b0;
            wakeOutNOeN    <= ~wakeActive;                  // [RULE1] [RULE9]
            wakeActiveLast <= wakeActive;
        end
    end

    // =====================================================================
    // Release history of our own drive
    // The line sample lags the pad by the synchroniser depth, so without
    // this our own release would look like a foreign pull for two cycles.
    // Reset to zero as well: the synchronised line level starts low after
    // reset while the pull-up holds the real line high.
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            releasedD1 <= 1'b0;
            releasedD2 <= 1'b0;
        end
        else
        begin
            releasedD1 <= wakeOutNOeN;
            releasedD2 <= releasedD1;
        end
    end

    // Released now and for the two samples the synchroniser still holds
    assign releasedSettled = wakeOutNOeN & releasedD1 & releasedD2;

    // =====================================================================
    // Interrupt events
    // New status from any source, our wake assertion, or another device
    // pulling the shared line while we leave it released
    assign irqSet[`WK_IRQ_NEW_STATUS]   = (|pinRise1) | (|pinRise2);
    assign irqSet[`WK_IRQ_WAKE_ASSERTED] = wakeActive & ~wakeActiveLast;
    assign irqSet[`WK_IRQ_FOREIGN_WAKE] = ~busLevel[0] & releasedSettled;

    // A read clears only the bits it returned, so later events survive
    assign irqClear = otherReset ? 3'h7 :
                      (readFire && regSel == wk_pkg::WK_SEL_IRQ_STATUS) ? prdata[2:0] : 3'h0;

    wk_sticky #(
        .WIDTH (3)
    ) u_irq_status (
        .mclk      (mclk),
        .srst      (srst),
        .setBits   (irqSet),
        .clearBits (irqClear),
        .flags     (irqStatus)
    );

    // =====================================================================
    // Interrupt mask; also cleared by the merged main-supply reset
    always_ff @(posedge mclk)
    begin
        if (srst)
            irqMask <= `WK_RESET_IRQ;
        else if (otherReset)
            irqMask <= `WK_RESET_IRQ;
        else if (laneZero && regSel == wk_pkg::WK_SEL_IRQ_MASK)
            irqMask <= pwdata[2:0];
    end

    // Level interrupt, high while any unmasked flag stands
    assign next_irq = |(irqStatus & irqMask);

    always_ff @(posedge mclk)
    begin
        if (srst)
            irq <= 1'b0;
        else
            irq <= next_irq;
    end

endmodule

// ==== wk_wake_gate_asserts.sv ====
// Checker for the wake gating block, seeing only its top-level ports.
// Assumes one clock domain, mclk, with srst as its synchronous reset.
`timescale 1ns/1ps
`include "wk_map.svh"

module wk_wake_gate_asserts (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        srst,
    // APB
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Sources and outputs
    input wire logic [7:0]  gpioWakeGroup1,
    input wire logic [7:0]  gpioWakeGroup2,
    input wire logic        wakeOutNOut,
    input wire logic        wakeOutNOeN,
    input wire logic        irq
);
    // =====================================================================
    // Helper logic
    logic       idxMapped;
    logic       cause;
    logic [7:0] prevG1;
    logic [7:0] prevG2;
    logic [3:0] quiet;

    // Index decode of every register the slave answers for
    assign idxMapped = paddr[7:2] inside {`WK_IDX_STATUS_GPIO_GROUP1, `WK_IDX_STATUS_GPIO_GROUP2,
        `WK_IDX_ENABLE_GPIO_GROUP1, `WK_IDX_ENABLE_GPIO_GROUP2, `WK_IDX_CONTROL, `WK_IDX_IRQ_STATUS,
        `WK_IDX_IRQ_MASK, `WK_IDX_PIN_LEVEL};
    // Only a write or a pin change may move the wake drive
    assign cause = (psel && penable && pready && pwrite) || (gpioWakeGroup1 != prevG1) || (gpioWakeGroup2 != prevG2);

    // Cycles since the last possible cause, saturating so it never wraps
    always_ff @(posedge mclk)
    begin
        prevG1 <= gpioWakeGroup1;
        prevG2 <= gpioWakeGroup2;
        quiet  <= (srst || cause) ? 4'h0 : ((quiet == 4'hf) ? quiet : quiet + 4'h1);
    end

    // =====================================================================
    // Assertions
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    a_reset_outputs_idle: assert property (disable iff (1'b0) srst |=> wakeOutNOeN && !irq && !pready)
        else $error("outputs not idle after reset");
    a_drive_value_low: assert property (wakeOutNOut == 1'b0)
        else $error("open-drain drive value not low");
    a_drive_needs_cause: assert property (quiet > 4'h6 |-> $stable(wakeOutNOeN))
        else $error("wake drive moved without a cause");
    a_one_wait_state: assert property (psel && !penable |=> !pready ##1 pready)
        else $error("answer not after exactly one wait state");
    a_ready_single_pulse: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    a_unmapped_error: assert property (pready && !idxMapped |-> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");
    a_mapped_no_error: assert property (pready && idxMapped |-> !pslverr && prdata[31:8] == 24'h00_0000)
        else $error("mapped access answered wrongly");
    a_write_data_zero: assert property (pready && pwrite |-> prdata == 32'h0000_0000)
        else $error("read data not zero during write");

    c_wake_driven: cover property ($fell(wakeOutNOeN));
    c_bus_error: cover property (pready && pslverr);
    c_irq_raised: cover property ($rose(irq));
endmodule

bind wk_wake_gate wk_wake_gate_asserts u_asserts (.mclk(mclk), .srst(srst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .gpioWakeGroup1(gpioWakeGroup1), .gpioWakeGroup2(gpioWakeGroup2), .wakeOutNOut(wakeOutNOut),
    .wakeOutNOeN(wakeOutNOeN), .irq(irq));
